// ===== verilog/lsau_core.sv
// load/store address unit: address forming, write-back, load extension
`timescale 1ns/10ps
module lsau_core #(
    parameter int IMM_W = 12
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic op_valid,
    output logic op_ready,
    input wire logic op_load,
    input wire lsau_pkg::lsau_size_type op_size,
    input wire logic op_signed,
    input wire lsau_pkg::lsau_mode_type op_mode,
    input wire logic op_unpriv,
    input wire logic op_sub,
    input wire logic [IMM_W-1:0] op_imm,
    input wire logic [1:0] left_shift_amount,
    input wire logic [3:0] op_cond,
    input wire logic [3:0] apsr_nzcv,
    input wire logic [3:0] transfer_reg,
    input wire logic [3:0] second_transfer_reg,
    input wire logic [3:0] base_reg,
    input wire logic [3:0] index_reg,
    input wire logic [31:0] base_val,
    input wire logic [31:0] index_val,
    input wire logic [31:0] store_val,
    input wire logic [31:0] store_val2,
    output logic mem_req,
    output logic mem_write,
    output lsau_pkg::lsau_size_type mem_size,
    output logic mem_unpriv,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic rf_we,
    output logic [3:0] rf_waddr,
    output logic [31:0] rf_wdata,
    output logic wb_we,
    output logic [3:0] wb_reg,
    output logic [31:0] wb_data,
    output logic branch_valid,
    output logic [31:0] branch_target,
    output logic flags_we,
    output logic op_fault,
    output logic op_done
);
    if (IMM_W != 12) begin : g_bad
        $error("lsau_core: IMM_W must be 12");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} lsau_st_type;

    logic rst_s1_q, rst_s2_q;
    lsau_st_type st_q;
    logic accept, cond_ok, bad, wback, pc_load;
    logic [31:0] ofs, idx_sum, acc_addr, ext_val;
    logic load_q, signed_q;
    lsau_pkg::lsau_size_type size_q;
    logic [3:0] rt2_q;
    logic [31:0] wdata2_q;

    // ==========================================================
    // reset release through two flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // ==========================================================
    // address forming
    assign op_ready = st_q == ST_IDLE;
    assign accept = op_valid && op_ready;
    assign cond_ok = lsau_pkg::lsau_cond_pass(op_cond, apsr_nzcv);
    assign wback = op_mode == lsau_pkg::LSAU_PRE ||
                   op_mode == lsau_pkg::LSAU_POST;
    // zero immediate leaves base as is
    assign ofs = op_mode == lsau_pkg::LSAU_REGOFF ?
                 index_val << left_shift_amount :
                 {20'h0_0000, op_imm};
    assign idx_sum = op_sub && op_mode != lsau_pkg::LSAU_REGOFF ?
                     base_val - ofs : base_val + ofs;
    assign acc_addr = op_mode == lsau_pkg::LSAU_POST ? base_val : idx_sum;
    assign pc_load = op_load && transfer_reg == lsau_pkg::LSAU_PC &&
                     op_size == lsau_pkg::LSAU_WORD;
    // flags are never written by this unit
    assign flags_we = 1'b0;

    // ==========================================================
    // operand checks; an offending operation is refused outright
    always_comb begin
        bad = 1'b0;
        if (op_mode != lsau_pkg::LSAU_REGOFF) begin
            if (op_size == lsau_pkg::LSAU_DUAL) begin
                bad = op_imm > lsau_pkg::LSAU_DUAL_MAX ||
                      (op_imm[1:0] & lsau_pkg::LSAU_DUAL_ALIGN) != 2'h0;
            end else if (op_mode != lsau_pkg::LSAU_OFFSET || op_sub) begin
                bad = op_imm > lsau_pkg::LSAU_IDX_MAX;
            end
        end
        if (op_unpriv && (op_mode != lsau_pkg::LSAU_OFFSET || op_sub ||
                          op_imm > lsau_pkg::LSAU_UNPRIV_MAX)) begin
            bad = 1'b1;
        end
        if (op_signed && !op_load) begin
            bad = 1'b1;
        end
        if ((transfer_reg == lsau_pkg::LSAU_SP ||
             transfer_reg == lsau_pkg::LSAU_PC) &&
            op_size != lsau_pkg::LSAU_WORD) begin
            bad = 1'b1;
        end
        if (!op_load && (transfer_reg == lsau_pkg::LSAU_PC ||
                         base_reg == lsau_pkg::LSAU_PC)) begin
            bad = 1'b1;
        end
        if (op_size == lsau_pkg::LSAU_DUAL && (op_load &&
            transfer_reg == second_transfer_reg)) begin
            bad = 1'b1;
        end
        if (wback && (base_reg == transfer_reg ||
            (op_size == lsau_pkg::LSAU_DUAL &&
             base_reg == second_transfer_reg))) begin
            bad = 1'b1;
        end
        if (op_mode == lsau_pkg::LSAU_REGOFF &&
            (index_reg == lsau_pkg::LSAU_SP ||
             index_reg == lsau_pkg::LSAU_PC ||
             base_reg == lsau_pkg::LSAU_PC ||
             op_size == lsau_pkg::LSAU_DUAL)) begin
            bad = 1'b1;
        end
    end

    // ==========================================================
    // sequencer: one request, or two for a dual transfer
    always_ff @(posedge mclk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (accept && cond_ok && !bad) begin
                        st_q <= ST_FIRST;
                    end
                end
                ST_FIRST: begin
                    if (mem_ack) begin
                        st_q <= size_q == lsau_pkg::LSAU_DUAL ?
                                ST_SECOND : ST_IDLE;
                    end
                end
                ST_SECOND: begin
                    if (mem_ack) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // memory request and latched operation
    always_ff @(posedge mclk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_size <= lsau_pkg::LSAU_WORD;
            mem_unpriv <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            load_q <= 1'b0;
            signed_q <= 1'b0;
            size_q <= lsau_pkg::LSAU_WORD;
            rt2_q <= 4'h0;
            wdata2_q <= 32'h0000_0000;
        end else if (st_q == ST_IDLE) begin
            mem_req <= accept && cond_ok && !bad;
            if (accept) begin
                mem_write <= !op_load;
                mem_size <= op_size;
                mem_unpriv <= op_unpriv;
                mem_addr <= acc_addr;
                // only the low lanes of narrow stores carry data
                case (op_size)
                    lsau_pkg::LSAU_BYTE:
                        mem_wdata <= {24'h00_0000, store_val[7:0]};
                    lsau_pkg::LSAU_HALF:
                        mem_wdata <= {16'h0000, store_val[15:0]};
                    default: mem_wdata <= store_val;
                endcase
                load_q <= op_load;
                signed_q <= op_signed;
                size_q <= op_size;
                rt2_q <= second_transfer_reg;
                wdata2_q <= store_val2;
            end
        end else if (mem_ack) begin
            // second word follows four bytes above the first
            mem_req <= st_q == ST_FIRST && size_q == lsau_pkg::LSAU_DUAL;
            mem_addr <= mem_addr + lsau_pkg::LSAU_WORD_STEP;
            mem_wdata <= wdata2_q;
        end
    end

    lsau_extend u_extend (
        .raw(mem_rdata),
        .size(size_q),
        .sign_ext(signed_q),
        .value(ext_val)
    );

    // ==========================================================
    // register file and branch results
    logic [3:0] rt_q;
    logic wb_pend_q, pc_pend_q;
    logic [31:0] wb_val_q;
    always_ff @(posedge mclk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            rf_we <= 1'b0;
            rf_waddr <= 4'h0;
            rf_wdata <= 32'h0000_0000;
            rt_q <= 4'h0;
            wb_pend_q <= 1'b0;
            pc_pend_q <= 1'b0;
            wb_val_q <= 32'h0000_0000;
            wb_we <= 1'b0;
            wb_reg <= 4'h0;
            wb_data <= 32'h0000_0000;
            branch_valid <= 1'b0;
            branch_target <= 32'h0000_0000;
            op_fault <= 1'b0;
            op_done <= 1'b0;
        end else begin
            rf_we <= 1'b0;
            wb_we <= 1'b0;
            branch_valid <= 1'b0;
            op_fault <= accept && cond_ok && bad;
            op_done <= accept && !(cond_ok && !bad);
            if (accept) begin
                rt_q <= transfer_reg;
                wb_pend_q <= wback;
                pc_pend_q <= pc_load;
                wb_reg <= base_reg;
                wb_val_q <= idx_sum;
            end
            if (st_q != ST_IDLE && mem_ack) begin
                rf_we <= load_q && !(pc_pend_q && st_q == ST_FIRST);
                rf_waddr <= st_q == ST_SECOND ? rt2_q : rt_q;
                rf_wdata <= ext_val;
                if (st_q == ST_SECOND || size_q != lsau_pkg::LSAU_DUAL) begin
                    op_done <= 1'b1;
                    wb_we <= wb_pend_q;
                    wb_data <= wb_val_q;
                    branch_valid <= pc_pend_q;
                    branch_target <= mem_rdata &
                                     lsau_pkg::LSAU_BRANCH_MASK;
                end
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_take_ok;
        accept && cond_ok && !bad;
    endsequence
    sequence s_take_off;
        s_take_ok ##0 op_mode == lsau_pkg::LSAU_OFFSET;
    endsequence

    offset_addr_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        s_take_off |=> mem_addr == $past(idx_sum) && mem_req)
        else $error("offset address wrong");
    offset_nowb_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        s_take_off |=> !wb_pend_q)
        else $error("offset mode wrote base");
    post_addr_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        s_take_ok ##0 op_mode == lsau_pkg::LSAU_POST
        |=> mem_addr == $past(base_val))
        else $error("post-index access not at base");
    dual_step_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        st_q == ST_FIRST && mem_ack && size_q == lsau_pkg::LSAU_DUAL
        |=> mem_req && mem_addr == $past(mem_addr) + 32'h0000_0004)
        else $error("dual second address wrong");
    branch_even_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        branch_valid |-> !branch_target[0] && !rf_we)
        else $error("branch target odd");
    cond_fail_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        accept && !cond_ok |=> !mem_req && op_done ##1 !wb_we)
        else $error("failed condition accessed memory");
    flags_keep_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        !flags_we)
        else $error("flags written");
    fault_refuse_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        accept && bad && cond_ok |=> op_fault && !mem_req)
        else $error("bad operand not refused");
    unpriv_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        s_take_ok ##0 op_unpriv |=> mem_unpriv)
        else $error("unprivileged access lost");
    sbyte_a: assert property (@(posedge mclk) disable iff (!rst_s2_q)
        rf_we && $past(signed_q && size_q == lsau_pkg::LSAU_BYTE)
        |-> rf_wdata[31:8] == {24{rf_wdata[7]}})
        else $error("signed byte not extended");
endmodule // lsau_core

// ===== verilog/lsau_pkg.sv
// constants, types and helpers shared by the load/store address unit
package lsau_pkg;
    // ==========================================================
    // operand encodings
    typedef enum logic [1:0] {
        LSAU_WORD, LSAU_BYTE, LSAU_HALF, LSAU_DUAL
    } lsau_size_type;
    typedef enum logic [1:0] {
        LSAU_OFFSET, LSAU_PRE, LSAU_POST, LSAU_REGOFF
    } lsau_mode_type;
    // ==========================================================
    // register numbers and limits
    localparam logic [3:0] LSAU_SP = 4'hd;
    localparam logic [3:0] LSAU_PC = 4'hf;
    localparam logic [11:0] LSAU_OFS_MAX = 12'hfff;
    localparam logic [11:0] LSAU_IDX_MAX = 12'h0ff;
    localparam logic [11:0] LSAU_DUAL_MAX = 12'h3fc;
    localparam logic [11:0] LSAU_UNPRIV_MAX = 12'h0ff;
    localparam logic [1:0] LSAU_DUAL_ALIGN = 2'h3;
    localparam logic [31:0] LSAU_WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] LSAU_BRANCH_MASK = 32'hffff_fffe;
    localparam logic [3:0] LSAU_COND_AL = 4'he;
    // ==========================================================
    // condition check against n z c v
    function automatic logic lsau_cond_pass(input logic [3:0] cond,
                                            input logic [3:0] f);
        logic n, z, c, v, r;
        n = f[3];
        z = f[2];
        c = f[1];
        v = f[0];
        case (cond[3:1])
            3'h0: r = z;
            3'h1: r = c;
            3'h2: r = n;
            3'h3: r = v;
            3'h4: r = c & ~z;
            3'h5: r = n == v;
            3'h6: r = ~z & (n == v);
            default: r = 1'b1;
        endcase
        // odd codes invert, except the always code family
        if (cond[0] && cond[3:1] != 3'h7) begin
            r = ~r;
        end
        return r;
    endfunction
endpackage

// ===== verilog/lsau_extend.sv
// load data extender: zero or sign extension of bytes and halfwords
`timescale 1ns/10ps
module lsau_extend (
    input wire logic [31:0] raw,
    input wire lsau_pkg::lsau_size_type size,
    input wire logic sign_ext,
    output logic [31:0] value
);
    // ==========================================================
    // extension by access size
    always_comb begin
        case (size)
            lsau_pkg::LSAU_BYTE: value = {{24{sign_ext & raw[7]}}, raw[7:0]};
            lsau_pkg::LSAU_HALF:
                value = {{16{sign_ext & raw[15]}}, raw[15:0]};
            default: value = raw;
        endcase
    end
endmodule // lsau_extend

// ===== dv/lsau_mem_model.sv
// memory partner model answering the unit's data bus
`timescale 1ns/10ps
module lsau_mem_model (
    input wire logic mclk,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] delay,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [64];
    logic [3:0] wait_q;
    // ==========================================
    // answer after delay waits; data line churns outside the ack cycle,
    // so a unit that samples it late never sees stale data by luck
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
        wait_q = 4'h0;
    end
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        // the ack cycle itself still shows the old request: skip it
        if (mem_req && !mem_ack) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= delay) begin
                wait_q <= 4'h0;
                mem_ack <= 1'b1;
                if (!mem_write) mem_rdata <= mem[mem_addr[7:2]];
            end
        end
    end
endmodule // lsau_mem_model

// ===== dv/testbench.sv
// self-checking bench for the load/store address unit
`timescale 1ns/10ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("Error at %0t: got %h exp %h", $time, (g), (e)); \
    end \
end
module testbench;
    logic mclk, resetn, op_valid, op_ready, op_load, op_signed, op_unpriv;
    logic op_sub, mem_req, mem_write, mem_unpriv, mem_ack, rf_we, wb_we;
    logic branch_valid, flags_we, op_fault, op_done, a_up, a_wr;
    logic [1:0] left_shift_amount;
    logic [3:0] op_cond, apsr_nzcv, transfer_reg, second_transfer_reg;
    logic [3:0] base_reg, index_reg, rf_waddr, wb_reg, delay, w_r;
    logic [11:0] op_imm;
    logic [31:0] base_val, index_val, store_val, store_val2, mem_addr;
    logic [31:0] mem_wdata, mem_rdata, rf_wdata, wb_data, branch_target;
    logic [31:0] w_d, b_t;
    logic [31:0] a_addr [4];
    logic [31:0] a_wd [4];
    logic [31:0] r_d [4];
    logic [3:0] r_a [4];
    lsau_pkg::lsau_size_type op_size, mem_size, a_sz;
    lsau_pkg::lsau_mode_type op_mode;
    int na, nr, nw, nb, nf, nfl, fails, total_checks;
    lsau_core dut_u (
        .mclk(mclk), .resetn(resetn), .op_valid(op_valid),
        .op_ready(op_ready), .op_load(op_load), .op_size(op_size),
        .op_signed(op_signed), .op_mode(op_mode), .op_unpriv(op_unpriv),
        .op_sub(op_sub), .op_imm(op_imm),
        .left_shift_amount(left_shift_amount), .op_cond(op_cond),
        .apsr_nzcv(apsr_nzcv), .transfer_reg(transfer_reg),
        .second_transfer_reg(second_transfer_reg), .base_reg(base_reg),
        .index_reg(index_reg), .base_val(base_val), .index_val(index_val),
        .store_val(store_val), .store_val2(store_val2), .mem_req(mem_req),
        .mem_write(mem_write), .mem_size(mem_size),
        .mem_unpriv(mem_unpriv), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
        .wb_we(wb_we), .wb_reg(wb_reg), .wb_data(wb_data),
        .branch_valid(branch_valid), .branch_target(branch_target),
        .flags_we(flags_we), .op_fault(op_fault), .op_done(op_done)
    );
    lsau_mem_model mem_u (
        .mclk(mclk), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .delay(delay), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );
    // ==========================================
    // clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ==========================================
    // monitor: log accesses and result pulses of the current operation
    always @(posedge mclk) begin
        if (flags_we !== 1'b0) nfl++;
        if (op_fault) nf++;
        if (mem_req && mem_ack && na < 4) begin
            a_addr[na] = mem_addr;
            a_wd[na] = mem_wdata;
            a_up = mem_unpriv;
            a_wr = mem_write;
            a_sz = mem_size;
            na++;
        end
        if (rf_we && nr < 4) begin
            r_d[nr] = rf_wdata;
            r_a[nr] = rf_waddr;
            nr++;
        end
        if (wb_we) begin
            w_d = wb_data;
            w_r = wb_reg;
            nw++;
        end
        if (branch_valid) begin
            b_t = branch_target;
            nb++;
        end
    end
    // ==========================================
    // drivers: quiet defaults, then one operation per call
    task automatic dflt();
        op_signed = 1'b0;
        op_unpriv = 1'b0;
        left_shift_amount = 2'h0;
        op_cond = lsau_pkg::LSAU_COND_AL;
        apsr_nzcv = 4'h0;
        transfer_reg = 4'h1;
        second_transfer_reg = 4'h2;
        base_reg = 4'h3;
        index_reg = 4'h4;
        base_val = 32'h0000_0100;
        index_val = 32'h0000_0010;
        store_val = 32'h1357_9bdf;
        store_val2 = 32'h2468_ace0;
        delay = 4'h0;
    endtask
    task automatic go(input logic ld, input lsau_pkg::lsau_size_type sz,
                      input lsau_pkg::lsau_mode_type md, input logic sb,
                      input logic [11:0] im);
        int n;
        @(posedge mclk);
        #1;
        op_load = ld;
        op_size = sz;
        op_mode = md;
        op_sub = sb;
        op_imm = im;
        {na, nr, nw, nb, nf} = '0;
        op_valid = 1'b1;
        for (n = 0; n < 50 && op_ready !== 1'b1; n++) @(posedge mclk);
        @(posedge mclk);
        #1;
        op_valid = 1'b0;
        for (n = 0; n < 60 && op_done !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        `CHK(op_done, 1'b1)
        // let the monitor log the done cycle before judging
        @(posedge mclk);
        #1;
        dflt();
    endtask
    // ==========================================
    // scenarios
    task automatic t_addr();
        mem_u.mem[6'h3f] = 32'hcafe_0001;
        go(1'b1, lsau_pkg::LSAU_WORD, lsau_pkg::LSAU_OFFSET, 1'b0, 12'hfff);
        `CHK({a_addr[0], r_d[0], nw}, {32'h10ff, 32'hcafe_0001, 0})
        go(1'b0, lsau_pkg::LSAU_WORD, lsau_pkg::LSAU_OFFSET, 1'b1, 12'h0ff);
        `CHK({a_addr[0], a_wd[0], a_wr, a_up}, {32'h1, 32'h1357_9bdf, 2'b10})
        `CHK(nr + nw, 0)
        go(1'b1, lsau_pkg::LSAU_WORD, lsau_pkg::LSAU_OFFSET, 1'b0, 12'h000);
        `CHK(a_addr[0], 32'h0000_0100)
        delay = 4'h3;
        go(1'b1, lsau_pkg::LSAU_WORD, lsau_pkg::LSAU_PRE, 1'b0, 12'h0ff);
        `CHK({a_addr[0], w_r, w_d}, {32'h1ff, 4'h3, 32'h1ff})
        store_val = 32'haaaa_5a5a;
        go(1'b0, lsau_pkg::LSAU_HALF, lsau_pkg::LSAU_POST, 1'b1, 12'h008);
        `CHK({a_addr[0], w_r, w_d}, {32'h100, 4'h3, 32'hf8})
        `CHK({a_sz, a_wd[0][15:0]}, {lsau_pkg::LSAU_HALF, 16'h5a5a})
        $display("test addressing done");
    endtask
    task automatic t_extend();
        logic [31:0] ea;
        logic [31:0] ex [4];
        ex = '{32'h96, 32'hffff_ff96, 32'h8a96, 32'hffff_8a96};
        for (int k = 0; k < 4; k++) begin
            ea = 32'h0000_0100 + (32'h0000_0010 << k);
            mem_u.mem[ea[7:2]] = 32'h1234_8a96;
            left_shift_amount = k[1:0];
            op_signed = k[0];
            go(1'b1, k < 2 ? lsau_pkg::LSAU_BYTE : lsau_pkg::LSAU_HALF,
               lsau_pkg::LSAU_REGOFF, 1'b0, 12'h000);
            `CHK(a_addr[0], ea)
            `CHK(r_d[0], ex[k])
        end
        // unconditional pc load, so no conditional block to end
        transfer_reg = lsau_pkg::LSAU_PC;
        mem_u.mem[6'h00] = 32'h0000_2469;
        go(1'b1, lsau_pkg::LSAU_WORD, lsau_pkg::LSAU_OFFSET, 1'b0, 12'h000);
        `CHK({nb, nr, b_t}, {1, 0, 32'h0000_2468})
        op_unpriv = 1'b1;
        go(1'b1, lsau_pkg::LSAU_BYTE, lsau_pkg::LSAU_OFFSET, 1'b0, 12'h0ff);
        `CHK({a_up, a_addr[0]}, {1'b1, 32'h0000_01ff})
        $display("test extend, branch, unprivileged done");
    endtask
    task automatic t_dual();
        go(1'b0, lsau_pkg::LSAU_DUAL, lsau_pkg::LSAU_PRE, 1'b0, 12'h3fc);
        `CHK({na, a_addr[0], a_addr[1]}, {2, 32'h4fc, 32'h500})
        `CHK({a_wd[0], a_wd[1]}, {32'h1357_9bdf, 32'h2468_ace0})
        `CHK(w_d, 32'h0000_04fc)
        mem_u.mem[6'h00] = 32'h0bad_0001;
        mem_u.mem[6'h01] = 32'h0bad_0002;
        delay = 4'h2;
        go(1'b1, lsau_pkg::LSAU_DUAL, lsau_pkg::LSAU_POST, 1'b1, 12'h008);
        `CHK({r_a[0], r_d[0]}, {4'h1, 32'h0bad_0001})
        `CHK({r_a[1], r_d[1], w_d}, {4'h2, 32'h0bad_0002, 32'hf8})
        $display("test dual done");
    endtask
    task automatic t_cond();
        logic [14:0] pass;
        pass = 15'h66a5;
        for (int c = 0; c < 15; c++) begin
            op_cond = c[3:0];
            apsr_nzcv = 4'b0110;
            go(1'b1, lsau_pkg::LSAU_WORD, lsau_pkg::LSAU_PRE, 1'b0, 12'h004);
            `CHK({na, nw}, {int'(pass[c]), int'(pass[c])})
        end
        $display("test condition done");
    endtask
    task automatic t_refuse();
        int szc [12] = '{3, 3, 0, 0, 1, 0, 3, 0, 2, 0, 0, 0};
        int mdc [12] = '{0, 1, 1, 0, 0, 3, 0, 2, 0, 0, 0, 0};
        logic [11:0] ldc = 12'h56d;
        logic [11:0] imc [12] = '{12'h3fe, 12'h400, 12'h100, 12'h100,
            12'h0, 12'h0, 12'h0, 12'h4, 12'h0, 12'h0, 12'h100, 12'h0};
        for (int k = 0; k < 12; k++) begin
            // one illegal operand per entry
            case (k)
                4: op_signed = 1'b1;
                5: index_reg = lsau_pkg::LSAU_SP;
                6: second_transfer_reg = 4'h1;
                7: base_reg = 4'h1;
                8: transfer_reg = lsau_pkg::LSAU_SP;
                9: base_reg = lsau_pkg::LSAU_PC;
                10: op_unpriv = 1'b1;
                11: transfer_reg = lsau_pkg::LSAU_PC;
                default: ;
            endcase
            go(ldc[k], lsau_pkg::lsau_size_type'(szc[k]),
               lsau_pkg::lsau_mode_type'(mdc[k]), k == 3, imc[k]);
            `CHK({nf, na + nr + nw}, {1, 0})
        end
        $display("test refusals done");
    endtask
    // ==========================================
    // verdict and end of run
    task automatic results();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(50 * 5000);
        fails++;
        results();
    end
    initial begin
        resetn = 1'b0;
        op_valid = 1'b0;
        op_load = 1'b0;
        op_size = lsau_pkg::LSAU_WORD;
        op_mode = lsau_pkg::LSAU_OFFSET;
        op_sub = 1'b0;
        op_imm = 12'h000;
        dflt();
        repeat (4) @(posedge mclk);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge mclk);
        t_addr();
        t_extend();
        t_dual();
        t_cond();
        t_refuse();
        `CHK(nfl, 0)
        results();
    end
endmodule // testbench
